//--- include/ppc_pkg.sv
// constants shared by the pack protection configuration block
package ppc_pkg;

	// register offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_OUT_CTL = 8'h01;
	localparam logic [7:0] OFS_FUNC_CTL = 8'h03;
	localparam logic [7:0] OFS_CELL_PICK = 8'h04;
	localparam logic [7:0] OFS_OL_THRESH = 8'h05;
	localparam logic [7:0] OFS_OL_BLANK = 8'h06;
	localparam logic [7:0] OFS_CHG_SHORT = 8'h07;
	localparam logic [7:0] OFS_DSG_SHORT = 8'h08;

	// output control fields
	localparam int OUT_LATCH_REL_BIT = 0;
	localparam int OUT_DIS_ON_BIT = 1;
	localparam int OUT_CHARGE_ON_BIT = 2;
	localparam int OUT_ZV_OFF_BIT = 3;
	localparam int OUT_PULL_BIT = 4;
	localparam int OUT_CTL_W = 5;
	localparam logic [4:0] OUT_CTL_RST = 5'h00;

	// function control fields
	localparam int FUNC_OL_OFF_BIT = 2;
	localparam int FUNC_CSHORT_OFF_BIT = 3;
	localparam int FUNC_DSHORT_OFF_BIT = 4;
	localparam int FUNC_CTL_W = 6;
	localparam logic [5:0] FUNC_CTL_RST = 6'h00;

	// status fields
	localparam int STAT_DSHORT_BIT = 0;
	localparam int STAT_CSHORT_BIT = 1;
	localparam int STAT_OL_BIT = 2;
	localparam int STAT_WDF_BIT = 3;

	// field layouts
	localparam int CELL_BYPASS_LSB = 4;
	localparam int OL_LEVEL_W = 5;
	localparam int OL_BLANK_W = 4;
	localparam int SHORT_LEVEL_LSB = 0;
	localparam int SHORT_DELAY_LSB = 4;
	localparam int NIB_W = 4;

	localparam logic [7:0] CELL_PICK_RST = 8'h00;
	localparam logic [4:0] OL_LEVEL_RST = 5'h00;
	localparam logic [3:0] OL_BLANK_RST = 4'h0;
	localparam logic [7:0] SHORT_CFG_RST = 8'h00;

	// timing: the delay base is the external 32 kHz watchdog clock
	localparam int CLK_HZ = 25_000_000;
	localparam int WDI_PERIOD_NS = 30518;
	localparam int SC_STEP_US = 61;
	localparam int OL_BASE_US = 1000;
	localparam int OL_STEP_US = 2000;
	localparam int WD_TIMEOUT_US = 100;
	localparam int SC_STEP_TICKS =
		(SC_STEP_US * 1000 + WDI_PERIOD_NS / 2) / WDI_PERIOD_NS;
	localparam int OL_BASE_TICKS =
		(OL_BASE_US * 1000 + WDI_PERIOD_NS / 2) / WDI_PERIOD_NS;
	localparam int OL_STEP_TICKS =
		(OL_STEP_US * 1000 + WDI_PERIOD_NS / 2) / WDI_PERIOD_NS;
	localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int TMR_W = 11;
	localparam int WD_W = 12;

	// serial target; address value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h10;

	typedef enum {
		I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_REG, I2C_REG_ACK,
		I2C_WDATA, I2C_WDATA_ACK, I2C_RDATA, I2C_RDATA_ACK
	} ppc_i2c_state_e;

endpackage : ppc_pkg

//--- hdl/ppc_i2c_target.sv
// serial register port: byte-wide target with auto-incrementing pointer
`timescale 1ns/10ps
module ppc_i2c_target
	import ppc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic regWe,
	input wire logic [7:0] regRdata
);

	logic sclM, sclS, sclD, sdaM, sdaS, sdaD;
	ppc_i2c_state_e st_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q, addr_q;
	logic rw_q, oeN_q, we_q, ack_q;

	// no reset on the synchronisers; the second and third stages are read
	always_ff @(posedge clk_sys)
	begin
		sclM <= sclIn;
		sclS <= sclM;
		sclD <= sclS;
		sdaM <= sdaIn;
		sdaS <= sdaM;
		sdaD <= sdaS;
	end

	wire startSeen = sclS & sclD & sdaD & ~sdaS;
	wire stopSeen = sclS & sclD & ~sdaD & sdaS;
	wire sclRise = sclS & ~sclD;
	wire sclFall = ~sclS & sclD;
	wire byteDone = (bitCnt_q == 4'h8);
	wire addrHit = (shift_q[7:1] == DEV_ADDR);
	wire rxState = (st_q == I2C_ADDR) | (st_q == I2C_REG) |
		(st_q == I2C_WDATA);

	always_ff @(posedge clk_sys)
	begin
		we_q <= 1'b0;
		if (rst)
		begin
			st_q <= I2C_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			addr_q <= 8'h00;
			rw_q <= 1'b0;
			oeN_q <= 1'b1;
			ack_q <= 1'b0;
		end
		else if (stopSeen)
		begin
			st_q <= I2C_IDLE;
			oeN_q <= 1'b1;
		end
		else if (startSeen)
		begin
			st_q <= I2C_ADDR;
			bitCnt_q <= 4'h0;
			oeN_q <= 1'b1;
		end
		else if (sclRise)
		begin
			if (rxState)
			begin
				shift_q <= {shift_q[6:0], sdaS};
				bitCnt_q <= bitCnt_q + 4'h1;
			end
			else if (st_q == I2C_RDATA)
				bitCnt_q <= bitCnt_q + 4'h1;
			else if (st_q == I2C_RDATA_ACK)
				ack_q <= ~sdaS;
		end
		else if (sclFall)
		begin
			unique case (st_q)
				I2C_IDLE: ;
				I2C_ADDR, I2C_REG, I2C_WDATA:
					if (byteDone)
					begin
						bitCnt_q <= 4'h0;
						if (st_q == I2C_ADDR)
						begin
							// foreign address: stay silent until next start
							st_q <= addrHit ? I2C_ADDR_ACK : I2C_IDLE;
							oeN_q <= ~addrHit;
							rw_q <= shift_q[0];
						end
						else if (st_q == I2C_REG)
						begin
							addr_q <= shift_q;
							st_q <= I2C_REG_ACK;
							oeN_q <= 1'b0;
						end
						else
						begin
							we_q <= 1'b1;
							st_q <= I2C_WDATA_ACK;
							oeN_q <= 1'b0;
						end
					end
				I2C_ADDR_ACK:
					if (rw_q)
					begin
						shift_q <= regRdata;
						oeN_q <= regRdata[7];
						bitCnt_q <= 4'h0;
						st_q <= I2C_RDATA;
					end
					else
					begin
						oeN_q <= 1'b1;
						st_q <= I2C_REG;
					end
				I2C_REG_ACK:
				begin
					oeN_q <= 1'b1;
					st_q <= I2C_WDATA;
				end
				I2C_WDATA_ACK:
				begin
					oeN_q <= 1'b1;
					addr_q <= addr_q + 8'h01;
					st_q <= I2C_WDATA;
				end
				I2C_RDATA:
					if (byteDone)
					begin
						oeN_q <= 1'b1;
						addr_q <= addr_q + 8'h01;
						st_q <= I2C_RDATA_ACK;
					end
					else
					begin
						shift_q <= {shift_q[6:0], 1'b0};
						oeN_q <= shift_q[6];
					end
				I2C_RDATA_ACK:
					if (ack_q)
					begin
						shift_q <= regRdata;
						oeN_q <= regRdata[7];
						bitCnt_q <= 4'h0;
						st_q <= I2C_RDATA;
					end
					else
						st_q <= I2C_IDLE;
			endcase
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOeN = oeN_q;
	assign regAddr = addr_q;
	assign regWdata = shift_q;
	assign regWe = we_q;

endmodule : ppc_i2c_target

//--- hdl/ppc_protect_cfg.sv
// pack protection configuration registers, delay timers and FET drive
`timescale 1ns/10ps
module ppc_protect_cfg
	import ppc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	input wire logic prechargeModeStrap,
	input wire logic wdiClk,
	input wire logic overloadTrip,
	input wire logic chargeShortTrip,
	input wire logic dischargeShortTrip,
	output logic chargeFetDrive,
	output logic dischargeFetDrive,
	output logic zeroVoltChargeGate,
	output logic openDrainOut,
	output logic openDrainOeN,
	output logic bottomCellBypassEn,
	output logic secondLowCellBypassEn,
	output logic secondHighCellBypassEn,
	output logic topCellBypassEn,
	output logic [3:0] cellMonSelect,
	output logic [4:0] overloadLevel,
	output logic [3:0] chargeShortLevel,
	output logic [3:0] dischargeShortLevel
);

	function automatic logic [TMR_W-1:0] shortLimit(input logic [3:0] code);
		shortLimit = TMR_W'(code) * TMR_W'(SC_STEP_TICKS);
	endfunction : shortLimit

	function automatic logic [TMR_W-1:0] blankLimit(input logic [3:0] code);
		blankLimit = TMR_W'(OL_BASE_TICKS) + TMR_W'(code) * TMR_W'(OL_STEP_TICKS);
	endfunction : blankLimit

	// register port
	logic [7:0] regAddr, regWdata, regRdata;
	logic regWe;

	ppc_i2c_target #(
		.DEV_ADDR(DEV_ADDR)
	) u_port (
		.clk_sys(clk_sys),
		.rst(rst),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOeN(sdaOeN),
		.regAddr(regAddr),
		.regWdata(regWdata),
		.regWe(regWe),
		.regRdata(regRdata)
	);

	// pin synchronisers
	logic strapM, strapS;
	logic wdiM, wdiS, wdiD;
	logic [2:0] tripM, tripS;
	always_ff @(posedge clk_sys)
	begin
		strapM <= prechargeModeStrap;
		strapS <= strapM;
		wdiM <= wdiClk;
		wdiS <= wdiM;
		wdiD <= wdiS;
		tripM <= {overloadTrip, dischargeShortTrip, chargeShortTrip};
		tripS <= tripM;
	end
	wire wdiTick = wdiS & ~wdiD;

	// configuration registers
	logic [OUT_CTL_W-1:0] outCtl_q;
	logic [FUNC_CTL_W-1:0] funcCtl_q;
	logic [7:0] cellPick_q, chgShort_q, dsgShort_q;
	logic [OL_LEVEL_W-1:0] olLevel_q;
	logic [OL_BLANK_W-1:0] olBlank_q;

	wire wrOut = regWe & (regAddr == OFS_OUT_CTL);
	wire wrFunc = regWe & (regAddr == OFS_FUNC_CTL);
	wire wrCell = regWe & (regAddr == OFS_CELL_PICK);
	wire wrOlThr = regWe & (regAddr == OFS_OL_THRESH);
	wire wrOlBlk = regWe & (regAddr == OFS_OL_BLANK);
	wire wrChgSc = regWe & (regAddr == OFS_CHG_SHORT);
	wire wrDsgSc = regWe & (regAddr == OFS_DSG_SHORT);

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			outCtl_q <= OUT_CTL_RST;
			// strap is held steady around reset; sync reset may sample it
			outCtl_q[OUT_CHARGE_ON_BIT] <= strapS;
		end
		else if (wrOut)
			outCtl_q <= regWdata[OUT_CTL_W-1:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			funcCtl_q <= FUNC_CTL_RST;
		else if (wrFunc)
			funcCtl_q <= regWdata[FUNC_CTL_W-1:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cellPick_q <= CELL_PICK_RST;
		else if (wrCell)
			cellPick_q <= regWdata;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			olLevel_q <= OL_LEVEL_RST;
			olBlank_q <= OL_BLANK_RST;
		end
		else
		begin
			if (wrOlThr)
				olLevel_q <= regWdata[OL_LEVEL_W-1:0];
			if (wrOlBlk)
				olBlank_q <= regWdata[OL_BLANK_W-1:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			chgShort_q <= SHORT_CFG_RST;
			dsgShort_q <= SHORT_CFG_RST;
		end
		else
		begin
			if (wrChgSc)
				chgShort_q <= regWdata;
			if (wrDsgSc)
				dsgShort_q <= regWdata;
		end
	end

	// field decode
	wire [3:0] chgDelayCode = chgShort_q[SHORT_DELAY_LSB +: NIB_W];
	wire [3:0] dsgDelayCode = dsgShort_q[SHORT_DELAY_LSB +: NIB_W];
	wire chgSenseOff = funcCtl_q[FUNC_CSHORT_OFF_BIT];
	wire dsgSenseOff = funcCtl_q[FUNC_DSHORT_OFF_BIT];
	wire olOff = funcCtl_q[FUNC_OL_OFF_BIT];

	// delay timers: channel 0 charge short, 1 discharge short, 2 overload
	logic [2:0] tripEn, expired;
	logic [TMR_W-1:0] limit [3];
	assign tripEn[0] = tripS[0] & ~chgSenseOff;
	assign tripEn[1] = tripS[1] & ~dsgSenseOff;
	assign tripEn[2] = tripS[2] & ~olOff;
	assign limit[0] = shortLimit(chgDelayCode);
	assign limit[1] = shortLimit(dsgDelayCode);
	assign limit[2] = blankLimit(olBlank_q);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_tmr
			logic [TMR_W-1:0] cnt_q;
			always_ff @(posedge clk_sys)
			begin
				if (rst || !tripEn[gi])
					cnt_q <= '0;
				else if (wdiTick && cnt_q != '1)
					cnt_q <= cnt_q + TMR_W'(1);
			end
			// delay counts in watchdog ticks; a dead 32 kHz clock stalls it
			assign expired[gi] = tripEn[gi] & (cnt_q >= limit[gi]);
		end
	endgenerate

	// watchdog on the 32 kHz input
	logic [WD_W-1:0] wdCnt_q;
	wire wdTimeout = (wdCnt_q == WD_W'(WD_TIMEOUT_CYC));
	always_ff @(posedge clk_sys)
	begin
		if (rst || wdiTick)
			wdCnt_q <= '0;
		else if (!wdTimeout)
			wdCnt_q <= wdCnt_q + WD_W'(1);
	end

	// latch release on a 0-1-0 sequence of the release bit
	logic relArmed_q;
	wire relBit = outCtl_q[OUT_LATCH_REL_BIT];
	wire latchRelease = relArmed_q & ~relBit;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			relArmed_q <= 1'b0;
		else
			relArmed_q <= relBit;
	end

	// fault latches; a new event beats a release in the same cycle
	logic chgShortFault_q, dsgShortFault_q, olFault_q, wdFault_q;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			chgShortFault_q <= 1'b0;
			dsgShortFault_q <= 1'b0;
			olFault_q <= 1'b0;
			wdFault_q <= 1'b0;
		end
		else
		begin
			chgShortFault_q <= expired[0] |
				(chgShortFault_q & ~latchRelease);
			dsgShortFault_q <= expired[1] |
				(dsgShortFault_q & ~latchRelease);
			olFault_q <= expired[2] | (olFault_q & ~latchRelease);
			wdFault_q <= wdTimeout | (wdFault_q & ~latchRelease);
		end
	end

	// FET drives
	wire shortFault = chgShortFault_q | dsgShortFault_q;
	wire chgOn = outCtl_q[OUT_CHARGE_ON_BIT] & ~shortFault &
		~wdFault_q;
	wire dsgOn = outCtl_q[OUT_DIS_ON_BIT] & ~shortFault & ~olFault_q &
		~wdFault_q;
	wire zvOn = ~outCtl_q[OUT_ZV_OFF_BIT] & ~shortFault;
	logic chgDrv_q, dsgDrv_q, zvDrv_q, pullOeN_q;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			chgDrv_q <= 1'b0;
			dsgDrv_q <= 1'b0;
			zvDrv_q <= 1'b0;
			pullOeN_q <= 1'b1;
		end
		else
		begin
			chgDrv_q <= chgOn;
			dsgDrv_q <= dsgOn;
			zvDrv_q <= zvOn;
			// host alone steers precharge through this pin
			pullOeN_q <= ~outCtl_q[OUT_PULL_BIT];
		end
	end

	// read mux; unmapped offsets read zero
	logic [7:0] statusVal;
	always_comb
	begin
		statusVal = 8'h00;
		statusVal[STAT_DSHORT_BIT] = dsgShortFault_q;
		statusVal[STAT_CSHORT_BIT] = chgShortFault_q;
		statusVal[STAT_OL_BIT] = olFault_q;
		statusVal[STAT_WDF_BIT] = wdFault_q;
	end

	always_comb
	begin
		unique case (regAddr)
			OFS_STATUS: regRdata = statusVal;
			OFS_OUT_CTL: regRdata = 8'(outCtl_q);
			OFS_FUNC_CTL: regRdata = 8'(funcCtl_q);
			OFS_CELL_PICK: regRdata = cellPick_q;
			OFS_OL_THRESH: regRdata = 8'(olLevel_q);
			OFS_OL_BLANK: regRdata = 8'(olBlank_q);
			OFS_CHG_SHORT: regRdata = chgShort_q;
			OFS_DSG_SHORT: regRdata = dsgShort_q;
			default: regRdata = 8'h00;
		endcase
	end

	assign chargeFetDrive = chgDrv_q;
	assign dischargeFetDrive = dsgDrv_q;
	assign zeroVoltChargeGate = zvDrv_q;
	assign openDrainOut = 1'b0;
	assign openDrainOeN = pullOeN_q;
	assign bottomCellBypassEn = cellPick_q[CELL_BYPASS_LSB];
	assign secondLowCellBypassEn = cellPick_q[CELL_BYPASS_LSB + 1];
	assign secondHighCellBypassEn = cellPick_q[CELL_BYPASS_LSB + 2];
	assign topCellBypassEn = cellPick_q[CELL_BYPASS_LSB + 3];
	assign cellMonSelect = cellPick_q[3:0];
	assign overloadLevel = olLevel_q;
	assign chargeShortLevel = chgShort_q[SHORT_LEVEL_LSB +: NIB_W];
	assign dischargeShortLevel = dsgShort_q[SHORT_LEVEL_LSB +: NIB_W];

endmodule : ppc_protect_cfg

//--- sim/ppc_protect_cfg_chk.sv
// port assertions for the protection config block
`timescale 1ns/10ps
module ppc_protect_cfg_chk
	import ppc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaOeN,
	input wire logic prechargeModeStrap,
	input wire logic chargeShortTrip,
	input wire logic dischargeShortTrip,
	input wire logic chargeFetDrive,
	input wire logic dischargeFetDrive,
	input wire logic zeroVoltChargeGate,
	input wire logic openDrainOeN,
	input wire logic bottomCellBypassEn,
	input wire logic secondLowCellBypassEn,
	input wire logic secondHighCellBypassEn,
	input wire logic topCellBypassEn,
	input wire logic [4:0] overloadLevel,
	input wire logic [3:0] chargeShortLevel,
	input wire logic [3:0] dischargeShortLevel
);
	wire logic [3:0] bypass = {topCellBypassEn, secondHighCellBypassEn,
		secondLowCellBypassEn, bottomCellBypassEn};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_reset_levels_zero:
		assert property ($fell(rst) |-> overloadLevel == 5'h00 &&
			chargeShortLevel == 4'h0 && dischargeShortLevel == 4'h0)
		else $error("level not zero after reset");
	a_reset_bypass_off:
		assert property ($fell(rst) |-> bypass == 4'h0)
		else $error("bypass on after reset");
	a_reset_chg_strap:
		assert property ($fell(rst) |-> ##[1:3]
			chargeFetDrive == prechargeModeStrap && zeroVoltChargeGate)
		else $error("charge drive not at strap level");
	a_reset_pins_free:
		assert property ($fell(rst) |-> openDrainOeN && sdaOeN)
		else $error("pin pulled low after reset");
	// writes land while the serial clock is low, never while it is high
	a_level_on_write:
		assert property ($changed({overloadLevel, chargeShortLevel,
			dischargeShortLevel}) |-> !sclIn)
		else $error("level moved outside a write");
	a_bypass_on_write:
		assert property ($changed(bypass) |-> !sclIn)
		else $error("bypass moved outside a write");
	a_od_on_write:
		assert property ($changed(openDrainOeN) |-> !sclIn)
		else $error("open drain moved outside a write");
	a_short_all_off:
		assert property ($fell(zeroVoltChargeGate) && sclIn |->
			!chargeFetDrive && !dischargeFetDrive)
		else $error("short left a drive on");
	a_short_has_cause:
		assert property ($fell(zeroVoltChargeGate) && sclIn |->
			$past(chargeShortTrip, 3) || $past(dischargeShortTrip, 3))
		else $error("drives cut without a short");
	cover property ($fell(zeroVoltChargeGate) && sclIn);
	cover property ($fell(openDrainOeN));
	cover property ($fell(dischargeFetDrive) && zeroVoltChargeGate);
endmodule : ppc_protect_cfg_chk

bind ppc_protect_cfg ppc_protect_cfg_chk chk_u (.clk_sys, .rst, .sclIn,
	.sdaOeN, .prechargeModeStrap, .chargeShortTrip, .dischargeShortTrip,
	.chargeFetDrive, .dischargeFetDrive, .zeroVoltChargeGate,
	.openDrainOeN, .bottomCellBypassEn, .secondLowCellBypassEn,
	.secondHighCellBypassEn, .topCellBypassEn, .overloadLevel,
	.chargeShortLevel, .dischargeShortLevel);

//--- sim/ppc_host_model.sv
// serial host model that reaches the block's registers
`timescale 1ns/10ps
module ppc_host_model
	import ppc_pkg::*;
#(
	parameter logic [6:0] ADDR = DEV_ADDR_DEFAULT
)
(
	input wire logic clk_sys,
	input wire logic sdaLine,
	output logic sclOut,
	output logic sdaOeN
);
	// six clocks a phase, above the three the target needs to sync
	localparam int HALF = 6;
	initial
	begin
		sclOut = 1'b1;
		sdaOeN = 1'b1;
	end
	task automatic half();
		repeat (HALF) @(negedge clk_sys);
	endtask : half
	// data moves only with the clock low; a released line reads high
	task automatic putBit(input logic b, output logic got);
		half();
		sdaOeN = b;
		half();
		sclOut = 1'b1;
		half();
		got = sdaLine;
		sclOut = 1'b0;
	endtask : putBit
	task automatic sendStart();
		half();
		sdaOeN = 1'b1;
		half();
		sclOut = 1'b1;
		half();
		sdaOeN = 1'b0;
		half();
		sclOut = 1'b0;
	endtask : sendStart
	task automatic sendStop();
		half();
		sdaOeN = 1'b0;
		half();
		sclOut = 1'b1;
		half();
		sdaOeN = 1'b1;
		half();
	endtask : sendStop
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			putBit(d[i], g);
		putBit(1'b1, g);
		ack = ~g;
	endtask : sendByte
	// single-byte reads only: the host answers with a not-acknowledge
	task automatic getByte(output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
		begin
			putBit(1'b1, g);
			d[i] = g;
		end
		putBit(1'b1, g);
	endtask : getByte
	task automatic writeReg(input logic [7:0] ofs,
		input logic [7:0] val, output logic ok);
		logic a0, a1, a2;
		sendStart();
		sendByte({ADDR, 1'b0}, a0);
		sendByte(ofs, a1);
		sendByte(val, a2);
		sendStop();
		ok = a0 & a1 & a2;
	endtask : writeReg
	task automatic readReg(input logic [7:0] ofs, output logic [7:0] val,
		output logic ok);
		logic a0, a1, a2;
		sendStart();
		sendByte({ADDR, 1'b0}, a0);
		sendByte(ofs, a1);
		sendStart();
		sendByte({ADDR, 1'b1}, a2);
		getByte(val);
		sendStop();
		ok = a0 & a1 & a2;
	endtask : readReg
endmodule : ppc_host_model

//--- sim/ppc_protect_cfg_bench.sv
// self-checking bench for the protection config block
`timescale 1ns/10ps
module ppc_protect_cfg_bench;
	import ppc_pkg::*;
	localparam int TICK_HALF = 381;
	localparam int LIMIT = 80000;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic prechargeModeStrap = 1'b1;
	logic wdiClk = 1'b0;
	logic overloadTrip = 1'b0;
	logic chargeShortTrip = 1'b0;
	logic dischargeShortTrip = 1'b0;
	logic sclIn, hostOeN, sdaOeN, chargeFetDrive, dischargeFetDrive;
	logic zeroVoltChargeGate, openDrainOeN, bottomCellBypassEn;
	logic secondLowCellBypassEn, secondHighCellBypassEn, topCellBypassEn;
	logic [3:0] cellMonSelect, chargeShortLevel, dischargeShortLevel;
	logic [4:0] overloadLevel;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	int wdiCnt = 0;
	// open-drain line with pull-up: any low enable pulls it down
	wire logic sdaIn = hostOeN & sdaOeN;
	wire logic [7:0] drv = {4'h0, openDrainOeN, chargeFetDrive,
		dischargeFetDrive, zeroVoltChargeGate};
	wire logic [7:0] cfgOut = {topCellBypassEn, secondHighCellBypassEn,
		secondLowCellBypassEn, bottomCellBypassEn, cellMonSelect};
	ppc_host_model host_u (.clk_sys, .sdaLine(sdaIn), .sclOut(sclIn),
		.sdaOeN(hostOeN));
	ppc_protect_cfg dut_u (.clk_sys, .rst, .sclIn, .sdaIn, .sdaOut(),
		.sdaOeN, .prechargeModeStrap, .wdiClk, .overloadTrip,
		.chargeShortTrip, .dischargeShortTrip, .chargeFetDrive,
		.dischargeFetDrive, .zeroVoltChargeGate, .openDrainOut(),
		.openDrainOeN, .bottomCellBypassEn, .secondLowCellBypassEn,
		.secondHighCellBypassEn, .topCellBypassEn, .cellMonSelect,
		.overloadLevel, .chargeShortLevel, .dischargeShortLevel);
	always #20 clk_sys = ~clk_sys;
	always @(negedge clk_sys)
	begin
		wdiCnt <= (wdiCnt == TICK_HALF - 1) ? 0 : wdiCnt + 1;
		if (wdiCnt == TICK_HALF - 1)
			wdiClk <= ~wdiClk;
	end
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
		logic ok;
		host_u.writeReg(ofs, val, ok);
		chk({7'h00, ok}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		host_u.readReg(ofs, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask : rd
	task automatic doReset(input logic strap);
		rst = 1'b1;
		prechargeModeStrap = strap;
		cyc(10);
		rst = 1'b0;
		cyc(4);
	endtask : doReset
	// a lone rising write must not release the latch
	task automatic clearFault(input logic [7:0] held);
		wr(OFS_OUT_CTL, 8'h07);
		cyc(2);
		chk(drv, held);
		wr(OFS_OUT_CTL, 8'h06);
		cyc(2);
		chk(drv, 8'h0f);
	endtask : clearFault
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial
	begin : main
		logic [7:0] mask [5] = '{8'hff, 8'h1f, 8'h0f, 8'hff, 8'hff};
		doReset(1'b1);
		chk(drv, 8'h0d);
		chk(cfgOut, 8'h00);
		for (int i = 4; i <= 8; i++)
		begin
			rd(8'(i), 8'h00);
			wr(8'(i), 8'ha5);
			rd(8'(i), 8'ha5 & mask[i - 4]);
		end
		chk(cfgOut, 8'ha5);
		chk({3'h0, overloadLevel}, 8'h05);
		chk({chargeShortLevel, dischargeShortLevel}, 8'h55);
		rd(8'h0f, 8'h00);
		$display("test registers done");
		wr(OFS_OUT_CTL, 8'h16);
		cyc(2);
		chk(drv, 8'h07);
		wr(OFS_OUT_CTL, 8'h06);
		cyc(2);
		chk(drv, 8'h0f);
		$display("test open drain done");
		wr(OFS_DSG_SHORT, 8'h00);
		dischargeShortTrip = 1'b1;
		cyc(20);
		chk(drv, 8'h08);
		rd(OFS_STATUS, 8'h01);
		dischargeShortTrip = 1'b0;
		clearFault(8'h08);
		$display("test discharge short done");
		wr(OFS_FUNC_CTL, 8'h08);
		wr(OFS_CHG_SHORT, 8'h10);
		chargeShortTrip = 1'b1;
		cyc(2000);
		chk(drv, 8'h0f);
		wr(OFS_FUNC_CTL, 8'h00);
		chk(drv, 8'h0f);
		cyc((SC_STEP_TICKS + 1) * 2 * TICK_HALF);
		chk(drv, 8'h08);
		chargeShortTrip = 1'b0;
		clearFault(8'h08);
		$display("test charge short done");
		wr(OFS_OL_BLANK, 8'h00);
		overloadTrip = 1'b1;
		cyc((OL_BASE_TICKS - 1) * 2 * TICK_HALF - 100);
		chk(drv, 8'h0f);
		cyc(3 * TICK_HALF);
		chk(drv, 8'h0d);
		rd(OFS_STATUS, 8'h04);
		overloadTrip = 1'b0;
		clearFault(8'h0d);
		$display("test overload done");
		doReset(1'b0);
		chk(drv, 8'h09);
		$display("test strap reset done");
		report_and_stop();
	end
endmodule : ppc_protect_cfg_bench
